// ==== src/dsj_core.sv ====
// execute unit for the decrement-skip-if-zero and immediate jump instructions
//
// Overview of operation
// - decode decrement-skip, read file, subtract one
// - destination bit picks working or file register
// - zero result flushes prefetched word, two cycles
// - top bits 101 decode jump, nine-bit target
// - jump target loads program counter bits 8:0
// - status bits 6:5 fill counter bits 10:9
`timescale 1ns/100ps
module dsj_core
  import dsj_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [dsj_word_w-1:0] prog_word,
  output logic [dsj_pc_w-1:0] prog_addr,
  output logic [dsj_addr_w-1:0] file_addr,
  input wire logic [dsj_data_w-1:0] file_rdata,
  output logic file_we,
  output logic [dsj_data_w-1:0] file_wdata,
  input wire logic [dsj_data_w-1:0] status_in,
  output logic [dsj_data_w-1:0] status_q,
  output logic [dsj_data_w-1:0] work_q,
  output logic [dsj_word_w-1:0] exec_word,
  output logic skip_taken,
  output logic jump_taken,
  output logic flushing
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic [dsj_pc_w-1:0] pc_q;
  logic [dsj_word_w-1:0] ir_q;
  dsj_state_type state_q, state_d;
  logic [dsj_data_w-1:0] work_d;

  // checks sample on the core clock and stand down while reset is applied
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire is_dec_skip = ir_q[dsj_word_w-1:dsj_dec_skip_lsb] == dsj_dec_skip_code;
  // jump match on top three bits
  wire is_jump = ir_q[dsj_word_w-1:dsj_jump_lsb] == dsj_jump_code;
  wire dest_file = ir_q[dsj_dest_bit];
  wire [dsj_imm_w-1:0] jump_imm = ir_q[dsj_imm_w-1:0];
  wire [dsj_data_w-1:0] dec_value = file_rdata - 8'h01;
  wire dec_zero = dec_value == 8'h00;
  wire do_skip = is_dec_skip && dec_zero;
  // page bits from status into upper counter bits
  wire [dsj_pc_w-1:0] jump_target = {status_q[dsj_page_hi:dsj_page_lo], jump_imm};
  // a jump always discards the sequential prefetch
  wire do_flush = do_skip || is_jump;

  // ----------------------------------------
  // decode checks
  // ----------------------------------------
  // jump decode exclusive
  jump_decode_a: assert property (
    ir_q[dsj_word_w-1:dsj_jump_lsb] == dsj_jump_code
    |-> jump_taken && !file_we && !skip_taken
  ) else $error("jump decode wrong");

  dec_decode_a: assert property (
    is_dec_skip |-> file_addr == exec_word[dsj_addr_w-1:0] && !jump_taken
  ) else $error("decrement operand address wrong");

  // skip on operand one
  // judged from the operand itself, so a broken subtractor cannot hide here
  skip_zero_a: assert property (
    is_dec_skip |-> skip_taken == (file_rdata == 8'h01)
  ) else $error("skip decision wrong");

  // ----------------------------------------
  // fetch
  // ----------------------------------------
  dsj_fetch fetch_i (
    .clk(clk),
    .reset(reset),
    .prog_word(prog_word),
    .load_pc(is_jump),
    .load_value(jump_target),
    .flush(do_flush),
    .pc_q(pc_q),
    .ir_q(ir_q)
  );

  assign prog_addr = pc_q;
  assign file_addr = ir_q[dsj_addr_w-1:0];
  assign exec_word = ir_q;
  // write back to file when destination bit set
  assign file_we = is_dec_skip && dest_file;
  assign file_wdata = dec_value;
  assign skip_taken = do_skip;
  assign jump_taken = is_jump;
  assign flushing = state_q == dsj_st_flush;

  // ----------------------------------------
  // write-back checks
  // ----------------------------------------
  // written value decremented
  dec_writeback_a: assert property (
    is_dec_skip && dest_file |-> file_we && file_wdata + 8'h01 == file_rdata
  ) else $error("file write-back wrong");

  // write strobe gated
  // a stray strobe would corrupt the file even while the core seems idle
  write_gate_a: assert property (
    file_we |-> is_dec_skip && exec_word[dsj_dest_bit]
  ) else $error("file written without destination bit");

  dec_nowrite_a: assert property (
    is_dec_skip && !dest_file |-> !file_we
  ) else $error("file written for working destination");

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  // working register takes result when destination bit clear
  assign work_d = (is_dec_skip && !dest_file) ? dec_value : work_q;
  // flush state marks the cycle that executes the discarded slot as a no-op
  assign state_d = do_flush ? dsj_st_flush : dsj_st_exec;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= dsj_st_exec;
      work_q <= dsj_work_reset;
      status_q <= dsj_status_reset;
    end else begin
      state_q <= state_d;
      work_q <= work_d;
      // status follows only the outside value, never these instructions
      status_q <= (is_dec_skip || is_jump) ? status_q : status_in;
    end
  end

  // ----------------------------------------
  // sequencing checks
  // ----------------------------------------
  // these look one edge after the instruction executed, at registered state, jump_flush_a also two; flush_nop_a checks the flushed slot in its own cycle
  // working register result
  work_update_a: assert property (
    is_dec_skip && !dest_file |=> work_q == $past(file_rdata) - 8'h01
  ) else $error("working register not updated");

  work_hold_a: assert property (
    !(is_dec_skip && !dest_file) |=> $stable(work_q)
  ) else $error("working register changed");

  skip_nop_a: assert property (
    do_skip |=> ir_q == dsj_nop_word && flushing
  ) else $error("skip did not flush");

  skip_advance_a: assert property (
    do_skip |=> pc_q == $past(pc_q) + 11'h001
  ) else $error("skip moved the counter");

  noskip_seq_a: assert property (
    is_dec_skip && !dec_zero && !flushing |=> pc_q == $past(pc_q) + 11'h001 && !flushing
  ) else $error("non-zero decrement stalled");

  jump_low_a: assert property (
    is_jump |=> pc_q[dsj_imm_w-1:0] == $past(ir_q[dsj_imm_w-1:0])
  ) else $error("jump low bits wrong");

  jump_page_a: assert property (
    is_jump |=> pc_q[dsj_pc_w-1:dsj_imm_w] == $past(status_q[dsj_page_hi:dsj_page_lo])
  ) else $error("jump page bits wrong");

  jump_flush_a: assert property (
    is_jump |=> ir_q == dsj_nop_word ##1 pc_q == $past(pc_q) + 11'h001
  ) else $error("jump did not flush");

  pc_step_a: assert property (
    !is_jump |=> pc_q == $past(pc_q) + 11'h001
  ) else $error("counter left its sequence");

  flush_single_a: assert property (
    flushing |=> !flushing
  ) else $error("flush lasted too long");

  flush_nop_a: assert property (
    flushing |-> exec_word == dsj_nop_word && !file_we && !jump_taken
  ) else $error("flushed slot executed");

  status_hold_a: assert property (
    is_dec_skip || is_jump |=> $stable(status_q)
  ) else $error("status changed");

  status_track_a: assert property (
    !(is_dec_skip || is_jump) |=> status_q == $past(status_in)
  ) else $error("status did not follow outside value");

  // ----------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------
  // hits here show the bench reached the main paths the checks above guard; the file write-back path has no cover of its own
  // taken skip followed by its discarded slot
  skip_cov: cover property (do_skip ##1 flushing);

  // jump whose target word runs right after the flush
  jump_cov: cover property (is_jump ##2 is_dec_skip);

  // decrement that does not skip
  noskip_cov: cover property (is_dec_skip && !dec_zero);

  // result kept in the working register
  work_cov: cover property (is_dec_skip && !dest_file);

  // jump into a page other than the one used first
  page_cov: cover property (is_jump && status_q[dsj_page_hi:dsj_page_lo] == 2'b01);
endmodule

// ==== src/dsj_pkg.sv ====
// package: encodings, field positions and widths for the decrement-skip and jump unit
package dsj_pkg;
  localparam int dsj_word_w = 12;
  localparam int dsj_data_w = 8;
  localparam int dsj_pc_w = 11;
  localparam int dsj_addr_w = 5;
  // decrement-skip-if-zero: 0010 11df ffff
  localparam logic [5:0] dsj_dec_skip_code = 6'h0b;
  localparam int dsj_dec_skip_lsb = 6;
  localparam int dsj_dest_bit = 5;
  // jump: 101k kkkk kkkk
  localparam logic [2:0] dsj_jump_code = 3'h5;
  localparam int dsj_jump_lsb = 9;
  localparam int dsj_imm_w = 9;
  // page select bits in status
  localparam int dsj_page_hi = 6;
  localparam int dsj_page_lo = 5;
  localparam logic [dsj_word_w-1:0] dsj_nop_word = 12'h000;
  localparam logic [dsj_pc_w-1:0] dsj_pc_reset = 11'h7ff;
  localparam logic [dsj_data_w-1:0] dsj_status_reset = 8'h18;
  localparam logic [dsj_data_w-1:0] dsj_work_reset = 8'h00;
  typedef enum logic [1:0] {
    dsj_st_exec = 2'b01,
    dsj_st_flush = 2'b10
  } dsj_state_type;
endpackage

// ==== src/dsj_fetch.sv ====
// fetch stage: program counter and prefetched instruction register
`timescale 1ns/100ps
module dsj_fetch
  import dsj_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [dsj_word_w-1:0] prog_word,
  input wire logic load_pc,
  input wire logic [dsj_pc_w-1:0] load_value,
  input wire logic flush,
  output logic [dsj_pc_w-1:0] pc_q,
  output logic [dsj_word_w-1:0] ir_q
);
  wire [dsj_pc_w-1:0] pc_d = load_pc ? load_value : pc_q + 11'h001;
  // a flushed slot becomes a no-operation rather than the fetched word
  wire [dsj_word_w-1:0] ir_d = flush ? dsj_nop_word : prog_word;

  always_ff @(posedge clk) begin
    if (reset) begin
      pc_q <= dsj_pc_reset;
      ir_q <= dsj_nop_word;
    end else begin
      pc_q <= pc_d;
      ir_q <= ir_d;
    end
  end
endmodule

// ==== bench/test_decrement_skip_and_jump_exec.sv ====
// self-checking testbench for the decrement-skip and jump unit
`timescale 1ns/100ps
module test_decrement_skip_and_jump_exec;
  import dsj_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic [11:0] prog_word = 12'h000;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] status_in = 8'h40;
  logic [10:0] prog_addr;
  logic [4:0] file_addr;
  logic [7:0] file_wdata, status_q, work_q;
  logic [11:0] exec_word;
  logic file_we, skip_taken, jump_taken, flushing;
  int fails = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  dsj_core u_dut (.clk(clk), .reset(reset), .prog_word(prog_word), .prog_addr(prog_addr),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
    .file_wdata(file_wdata), .status_in(status_in), .status_q(status_q), .work_q(work_q),
    .exec_word(exec_word), .skip_taken(skip_taken), .jump_taken(jump_taken),
    .flushing(flushing));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // status_in moves during execution so a held status shows up
  task automatic issue(input logic [11:0] w, input logic [11:0] nxt, input logic [7:0] rd);
    @(negedge clk) prog_word = w;
    @(negedge clk) prog_word = nxt;
    file_rdata = rd;
    status_in = 8'h00;
    #0.5;
  endtask
  task automatic after_exec(input logic fl, input logic [7:0] w);
    @(negedge clk);
    chk(status_q, 12'h040);
    chk(flushing, fl);
    chk(work_q, w);
    prog_word = 12'h000;
    status_in = 8'h40;
  endtask
  task automatic dec_skip_file();
    issue(12'h2ed, 12'h2c7, 8'h01);
    chk(file_addr, 12'h00d);
    chk({file_we, skip_taken, jump_taken}, 12'h006);
    chk(file_wdata, 12'h000);
    after_exec(1'b1, 8'h00);
    chk(exec_word, 12'h000);
  endtask
  task automatic dec_to_work();
    issue(12'h2df, 12'h000, 8'h00);
    chk(file_addr, 12'h01f);
    chk({file_we, skip_taken, jump_taken}, 12'h000);
    chk(file_wdata, 12'h0ff);
    after_exec(1'b0, 8'hff);
  endtask
  task automatic jump_paged();
    issue(12'hba5, 12'h2ed, 8'h01);
    chk({file_we, skip_taken, jump_taken}, 12'h001);
    after_exec(1'b1, 8'hff);
    chk(prog_addr, 12'h5a5);
    chk(exec_word, 12'h000);
  endtask
  // jump into page 1, then let the word at the target run
  task automatic jump_resume();
    @(negedge clk) status_in = 8'h20;
    issue(12'hb0f, 12'h2ed, 8'h05);
    chk(jump_taken, 12'h001);
    @(negedge clk);
    chk(prog_addr, 12'h30f);
    chk(flushing, 12'h001);
    chk(exec_word, 12'h000);
    prog_word = 12'h2c3;
    @(negedge clk);
    chk(exec_word, 12'h2c3);
    chk(prog_addr, 12'h310);
    @(negedge clk);
    chk(work_q, 12'h004);
    prog_word = 12'h000;
    status_in = 8'h40;
  endtask
  // reset in mid-run with a jump word waiting, then the first fetch after release
  task automatic reset_mid();
    @(negedge clk);
    reset = 1;
    prog_word = 12'hba5;
    repeat (2) @(negedge clk);
    chk(prog_addr, dsj_pc_reset);
    chk(exec_word, dsj_nop_word);
    chk(work_q, dsj_work_reset);
    chk(status_q, dsj_status_reset);
    chk(flushing, 12'h000);
    reset = 0;
    prog_word = 12'h000;
    @(negedge clk);
    chk(prog_addr, 12'h000);
    chk(jump_taken, 12'h000);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset = 0;
    repeat (2) @(negedge clk);
    dec_skip_file();
    dec_to_work();
    jump_paged();
    jump_resume();
    reset_mid();
    complete_run();
  end
  // the scenarios need about 35 cycles; this allows far more
  initial begin
    #2000;
    fails++;
    complete_run();
  end
endmodule
